// [design/offset_mirror.sv]
// AHB-Lite register bank for the aging offset and interrupt enable mirror register.
`timescale 1ns/1ps

// Operation
// - After the first refresh interval, load the stored value into the mirror.
// - The register resets to zero: enables cleared, offset zero.
// - The register can always be read, protected or not.
// - Writes are dropped while password protection is active.
// - The low six bits hold the oscillator aging offset.
// - Bit 7 enables the reset interrupt, bit 6 the low voltage interrupt.
// - Enabled reset interrupt holds until software clears the reset flag.
// - Enabled low voltage event raises the interrupt; disabled sets only its status flag, which raises the interrupt once enabled.
module offset_mirror #(
    parameter int first_refresh_cycles = offset_mirror_pkg::FIRST_REFRESH_CYCLES
) (
    input  wire logic                                hclk,          // Bus clock.
    input  wire logic                                hresetn,       // Reset, active low.
    input  wire logic                                hsel,          // Slave select.
    input  wire logic [31:0]                         haddr,         // Byte address.
    input  wire logic [1:0]                          htrans,        // Transfer type.
    input  wire logic                                hwrite,        // Write when high.
    input  wire logic [2:0]                          hsize,         // Transfer size.
    input  wire logic [31:0]                         hwdata,        // Write data.
    input  wire logic                                hready,        // Bus ready in.
    output logic [31:0]                              hrdata,        // Read data.
    output logic                                     hreadyout,     // Slave ready.
    output logic                                     hresp,         // Response, OKAY.
    input  wire logic [7:0]                          stored_value,  // Non-volatile copy.
    input  wire logic                                write_protect, // Password lock.
    input  wire logic                                low_voltage,   // Low voltage level.
    output logic                                     irq,           // Interrupt, high.
    output logic signed [offset_mirror_pkg::OFFSET_WIDTH-1:0] aging_offset, // Signed trim.
    output logic                                     mirror_loaded  // Load finished.
);
    import offset_mirror_pkg::*;

    // ==================================================================
    // Pin synchronisers
    // ==================================================================
    logic [7:0] stored_meta;
    logic [7:0] stored_sync;
    logic       protect_meta;
    logic       protect_sync;
    logic       lv_meta;
    logic       lv_sync;
    logic       lv_last;

    // Each pin passes two flops, low voltage a third for its edge; no logic reads the first stage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stored_meta  <= 8'h00;
            stored_sync  <= 8'h00;
            protect_meta <= 1'b0;
            protect_sync <= 1'b0;
            lv_meta      <= 1'b0;
            lv_sync      <= 1'b0;
            lv_last      <= 1'b0;
        end else begin
            stored_meta  <= stored_value;
            stored_sync  <= stored_meta;
            protect_meta <= write_protect;
            protect_sync <= protect_meta;
            lv_meta      <= low_voltage;
            lv_sync      <= lv_meta;
            lv_last      <= lv_sync;
        end
    end

    // ==================================================================
    // First refresh timing
    // ==================================================================
    logic load_pulse;
    logic load_done;

    first_refresh_timer #(
        .refresh_cycles (first_refresh_cycles)
    ) refresh_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .expired (load_pulse),
        .done    (load_done)
    );

    // ==================================================================
    // Bus address phase capture
    // ==================================================================
    ahb_phase_type pending;
    wire           take_phase = hsel && htrans[1] && hready;
    wire [ADDR_WIDTH-1:0] phase_addr = haddr[ADDR_WIDTH-1:0];
    wire           addr_in_range = (haddr[31:ADDR_WIDTH] == '0);

    // The slave never stalls, so every in-range address phase is taken when hready is high.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending <= '0;
        end else if (hready) begin
            pending.valid <= take_phase && addr_in_range;
            pending.write <= hwrite;
            pending.addr  <= phase_addr;
        end
    end

    // ==================================================================
    // Write decode for the data phase
    // ==================================================================
    wire data_write   = pending.valid && pending.write;
    wire hit_config   = data_write && (pending.addr == CONFIG_ADDR);
    wire hit_status   = data_write && (pending.addr == IRQ_STATUS_ADDR);
    wire hit_mask     = data_write && (pending.addr == IRQ_MASK_ADDR);
    wire config_write = hit_config && !protect_sync;
    wire config_block = hit_config && protect_sync;

    // ==================================================================
    // Register state and next values
    // ==================================================================
    logic [7:0]           config_reg;
    logic [EVT_COUNT-1:0] irq_status;
    logic [EVT_COUNT-1:0] irq_mask;
    logic [7:0]           next_config;
    logic [EVT_COUNT-1:0] next_status;
    logic [EVT_COUNT-1:0] next_mask;
    event_type            events;

    // Events seen this cycle; a low voltage event is the rising edge of the level.
    assign events.power_on_reset = 1'b0;
    assign events.low_voltage    = lv_sync && !lv_last;
    assign events.loaded         = load_pulse;
    assign events.reject         = config_block;

    // The load wins over a bus write in the same cycle, as the stored copy is the reference.
    assign next_config = load_pulse   ? stored_sync :
                         config_write ? hwdata[7:0] : config_reg;

    // A set in the cycle of a clear wins, so no event is lost.
    assign next_status = (irq_status & ~(hit_status ? hwdata[EVT_COUNT-1:0] : '0))
                         | events;
    assign next_mask   = hit_mask ? hwdata[EVT_COUNT-1:0] : irq_mask;

    // ==================================================================
    // Register update
    // ==================================================================
    // The power on reset flag is set by the reset itself and waits for software.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_reg <= CONFIG_RESET;
            irq_status <= IRQ_STATUS_RESET;
            irq_mask   <= IRQ_MASK_RESET;
        end else begin
            config_reg <= next_config;
            irq_status <= next_status;
            irq_mask   <= next_mask;
        end
    end

    // ==================================================================
    // Interrupt gating
    // ==================================================================
    wire por_enable = config_reg[POR_IRQ_ENABLE_BIT];
    wire lv_enable  = config_reg[LV_IRQ_ENABLE_BIT];
    wire [EVT_COUNT-1:0] gate;

    // The two documented enables sit in series with the mask for their own events.
    assign gate[EVT_POR_BIT]         = irq_mask[EVT_POR_BIT] && por_enable;
    assign gate[EVT_LOW_VOLTAGE_BIT] = irq_mask[EVT_LOW_VOLTAGE_BIT] && lv_enable;
    assign gate[EVT_LOADED_BIT]      = irq_mask[EVT_LOADED_BIT];
    assign gate[EVT_REJECT_BIT]      = irq_mask[EVT_REJECT_BIT];
    wire   next_irq = |(next_status & gate);

    // ==================================================================
    // Read decode
    // ==================================================================
    wire        read_take = take_phase && !hwrite && addr_in_range;
    wire [31:0] state_word = {30'h0, protect_sync, load_done};
    wire [31:0] config_word = {24'h0, next_config};
    wire [31:0] status_word = {28'h0, next_status};
    wire [31:0] mask_word   = {28'h0, next_mask};

    // Config, status and mask read data come from next values so a read right after a write sees the write.
    wire [31:0] read_word =
        !read_take                      ? 32'h0000_0000 :
        (phase_addr == CONFIG_ADDR)     ? config_word   :
        (phase_addr == IRQ_STATUS_ADDR) ? status_word   :
        (phase_addr == IRQ_MASK_ADDR)   ? mask_word     :
        (phase_addr == STATE_ADDR)      ? state_word    : 32'h0000_0000;

    // ==================================================================
    // Registered outputs
    // ==================================================================
    // Zero wait states keep hreadyout high; narrower sizes act as word accesses.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata        <= 32'h0000_0000;
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            irq           <= 1'b0;
            aging_offset  <= '0;
            mirror_loaded <= 1'b0;
        end else begin
            if (hready) begin
                hrdata <= read_word;
            end
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            irq           <= next_irq;
            aging_offset  <= signed'(next_config[OFFSET_MSB:0]);
            mirror_loaded <= load_done || load_pulse;
        end
    end

    // The transfer size is accepted without check; every register is one word.
    wire unused_size = ^hsize;

endmodule

// [design/offset_mirror_pkg.sv]
// Package with the register map, field layout, reset values and timing of the offset mirror.
package offset_mirror_pkg;

    // ==================================================================
    // Register map
    // ==================================================================
    // The configuration register index is not word aligned, so the byte address is four times it.
    localparam logic [7:0]  CONFIG_INDEX     = 8'hC1;
    localparam logic [11:0] CONFIG_ADDR      = {2'h0, CONFIG_INDEX, 2'h0};
    localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h400;
    localparam logic [11:0] IRQ_MASK_ADDR    = 12'h404;
    localparam logic [11:0] STATE_ADDR       = 12'h408;
    localparam int          ADDR_WIDTH       = 12;

    // ==================================================================
    // Field layout and reset values
    // ==================================================================
    localparam int          POR_IRQ_ENABLE_BIT = 7;
    localparam int          LV_IRQ_ENABLE_BIT  = 6;
    localparam int          OFFSET_MSB         = 5;
    localparam int          OFFSET_WIDTH       = 6;
    localparam logic [7:0]  CONFIG_RESET       = 8'h00;

    // Interrupt status and mask share one layout.
    localparam int          EVT_POR_BIT        = 0;
    localparam int          EVT_LOW_VOLTAGE_BIT = 1;
    localparam int          EVT_LOADED_BIT     = 2;
    localparam int          EVT_REJECT_BIT     = 3;
    localparam int          EVT_COUNT          = 4;
    localparam logic [3:0]  IRQ_STATUS_RESET   = 4'h1;
    localparam logic [3:0]  IRQ_MASK_RESET     = 4'h3;

    // ==================================================================
    // Timing
    // ==================================================================
    localparam int          CLOCK_PERIOD_NS       = 100;
    localparam int          FIRST_REFRESH_TIME_US = 66000;
    // A least time, so the count rounds up.
    localparam int          FIRST_REFRESH_CYCLES  =
        (FIRST_REFRESH_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int          REFRESH_COUNT_WIDTH   = 24;

    // ==================================================================
    // Carriers
    // ==================================================================
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [ADDR_WIDTH-1:0] addr;
    } ahb_phase_type;

    typedef struct packed {
        logic reject;
        logic loaded;
        logic low_voltage;
        logic power_on_reset;
    } event_type;

endpackage

// [design/first_refresh_timer.sv]
// Timer that marks the end of the first refresh interval after reset.
`timescale 1ns/1ps
module first_refresh_timer #(
    parameter int refresh_cycles = offset_mirror_pkg::FIRST_REFRESH_CYCLES
) (
    input  wire logic hclk,     // System clock.
    input  wire logic hresetn,  // Asynchronous reset, active low.
    output logic      expired,  // One-cycle pulse when the interval ends.
    output logic      done      // Level, high once the interval has ended.
);
    import offset_mirror_pkg::*;

    localparam logic [REFRESH_COUNT_WIDTH-1:0] LAST_COUNT =
        REFRESH_COUNT_WIDTH'(refresh_cycles - 1);

    logic [REFRESH_COUNT_WIDTH-1:0] count;
    wire                            at_end = (count == LAST_COUNT) && !done;

    // ==================================================================
    // Interval counter
    // ==================================================================
    // The counter stops once done so it never wraps and reloads a second time.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count   <= '0;
            expired <= 1'b0;
            done    <= 1'b0;
        end else begin
            expired <= at_end;
            if (at_end) begin
                done <= 1'b1;
            end else if (!done) begin
                count <= count + 1'b1;
            end
        end
    end

endmodule

// [dv/offset_mirror_asserts.sv]
// Port checker of the offset mirror register bank, with its bind.
`timescale 1ns/1ps
module offset_mirror_asserts #(
    parameter int first_refresh_cycles = 20
) (
    input wire logic        hclk,          // Clock.
    input wire logic        hresetn,       // Reset, low.
    input wire logic        hsel,          // Select.
    input wire logic [31:0] haddr,         // Address.
    input wire logic [1:0]  htrans,        // Transfer.
    input wire logic        hwrite,        // Write.
    input wire logic [31:0] hwdata,        // Write data.
    input wire logic        hready,        // Ready in.
    input wire logic        hresp,         // Response.
    input wire logic        hreadyout,     // Ready out.
    input wire logic [7:0]  stored_value,  // Stored copy.
    input wire logic        write_protect, // Lock.
    input wire logic        irq,           // Interrupt.
    input wire logic signed [offset_mirror_pkg::OFFSET_WIDTH-1:0] aging_offset, // Trim.
    input wire logic        mirror_loaded  // Loaded.
);
    import offset_mirror_pkg::*;
    logic [7:0] cnt;
    logic [2:0] wp_hi;
    logic [2:0] wp_lo;
    wire logic  cfg_wr = hsel && htrans[1] && hready && hwrite && haddr == {20'h0, CONFIG_ADDR};

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Helper counters
    // ==========================================================
    // Lock levels count cycles of a steady pin from the first; the checks wait past the two-flop sync.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt   <= 8'h00;
            wp_hi <= 3'h0;
            wp_lo <= 3'h0;
        end else begin
            cnt   <= (cnt == 8'hFF) ? cnt : cnt + 8'h01;
            wp_hi <= !write_protect ? 3'h0 : (wp_hi == 3'h7) ? wp_hi : wp_hi + 3'h1;
            wp_lo <= write_protect ? 3'h0 : (wp_lo == 3'h7) ? wp_lo : wp_lo + 3'h1;
        end
    end

    chk_reset_quiet: assert property (
        $rose(hresetn) |-> !irq && !mirror_loaded && aging_offset == '0)
        else $error("outputs not quiet after reset");
    chk_load_early: assert property (cnt < first_refresh_cycles |-> !mirror_loaded)
        else $error("mirror loaded too early");
    chk_load_late: assert property (cnt == first_refresh_cycles + 3 |-> mirror_loaded)
        else $error("mirror not loaded in time");
    chk_load_value: assert property (
        $rose(mirror_loaded) |-> ##[0:2] aging_offset == stored_value[5:0])
        else $error("loaded offset differs from stored value");
    chk_loaded_holds: assert property (mirror_loaded |=> mirror_loaded)
        else $error("loaded flag dropped");
    chk_locked_stable: assert property (
        wp_hi > 3'h5 && $past(mirror_loaded) |-> $stable(aging_offset))
        else $error("offset changed while locked");
    chk_write_offset: assert property (
        cfg_wr && wp_lo > 3'h5 && mirror_loaded |=> ##2 aging_offset == $past(hwdata[5:0], 2))
        else $error("unlocked write not applied to offset");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule

bind offset_mirror offset_mirror_asserts #(.first_refresh_cycles(first_refresh_cycles)) u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hresp,
    .hreadyout, .stored_value, .write_protect, .irq, .aging_offset, .mirror_loaded);

// [dv/testbench.sv]
// Self-checking bench of the offset mirror register bank.
`timescale 1ns/1ps
module testbench;
    import offset_mirror_pkg::*;
    logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic              write_protect = 1'b0, low_voltage = 1'b0;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [7:0]        stored_value = 8'h00, v;
    logic              hreadyout, hresp, irq, mirror_loaded;
    logic signed [5:0] aging_offset;
    int                errors = 0, check_count = 0;

    // Short refresh count keeps the run brief.
    offset_mirror #(.first_refresh_cycles(20)) u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stored_value,
        .write_protect, .low_voltage, .irq, .aging_offset, .mirror_loaded);

    // Free-running bus clock.
    always #50 hclk = ~hclk;

    // ==========================================================
    // Tasks and expectations
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // One single word transfer; the data phase waits on ready like the address phase.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [31:0] sext(input logic [7:0] b);
        return b[5] ? {26'h3FFFFFF, b[5:0]} : {26'h0, b[5:0]};
    endfunction

    function automatic logic [31:0] irq_of(input logic [7:0] c, input logic [3:0] s);
        return {31'h0, |(s & 4'h3 & {2'h3, c[6], c[7]})};
    endfunction

    task automatic tally_and_finish();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need.
    initial begin
        #300000;
        errors++;
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'hD5A591C3));
        stored_value <= 8'($urandom);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, CONFIG_ADDR, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rd, 32'h1);
        bus(1'b0, IRQ_MASK_ADDR, 32'h0);
        check(rd, 32'h3);
        // Before the load the state word shows neither load done nor lock.
        bus(1'b0, STATE_ADDR, 32'h0);
        check(rd, 32'h0);
        // An early write must be replaced by the stored copy.
        bus(1'b1, CONFIG_ADDR, {24'h0, ~stored_value});
        for (int i = 0; i < 60 && mirror_loaded !== 1'b1; i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
        bus(1'b0, CONFIG_ADDR, 32'h0);
        check(rd, {24'h0, stored_value});
        check({31'h0, irq}, irq_of(stored_value, 4'h5));
        // Corner offsets first, then random bytes with junk in the upper lanes.
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 8'h1F : (i == 1) ? 8'hA0 : (i == 2) ? 8'h40 : 8'($urandom);
            bus(1'b1, CONFIG_ADDR, {24'($urandom), v});
            bus(1'b0, CONFIG_ADDR, 32'h0);
            check(rd, {24'h0, v});
            check(32'(aging_offset), sext(v));
            check({31'h0, irq}, irq_of(v, 4'h5));
        end
        write_protect <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(1'b1, CONFIG_ADDR, {24'h0, ~v});
        bus(1'b0, CONFIG_ADDR, 32'h0);
        check(rd, {24'h0, v});
        bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rd, 32'hD);
        // Load done and the synchronised lock both read back as set.
        bus(1'b0, STATE_ADDR, 32'h0);
        check(rd, 32'h3);
        write_protect <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b1, CONFIG_ADDR, 32'h80);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, IRQ_STATUS_ADDR, 32'hF);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, CONFIG_ADDR, 32'h0);
        low_voltage <= 1'b1;
        repeat (8) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rd, 32'h2);
        bus(1'b1, CONFIG_ADDR, 32'h40);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, IRQ_MASK_ADDR, 32'h0);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, IRQ_MASK_ADDR, 32'h3);
        bus(1'b1, IRQ_STATUS_ADDR, 32'h2);
        low_voltage <= 1'b0;
        repeat (4) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        low_voltage <= 1'b1;
        for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 12'h010, 32'hFF);
        bus(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0);
        tally_and_finish();
    end
endmodule
